// *** abort_cause_pkg.sv ***
/*
  Shared constants and types for the transmit-abort cause logic of a
  two-wire bus controller: register map, field positions, reset values,
  master event phases and the event carrier.
  Assumes a 32-bit byte-addressed register port with one word per register.
*/
package abort_cause_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_CONFIG      = 32'h5000_1300;
  localparam logic [31:0] ADDR_TARGET      = 32'h5000_1304;
  localparam logic [31:0] ADDR_DATA_CMD    = 32'h5000_1310;
  localparam logic [31:0] ADDR_ABORT_CAUSE = 32'h5000_1380;
  localparam logic [31:0] ADDR_ABORT_CLEAR = 32'h5000_13a0;

  // Reset values
  localparam logic [15:0] CAUSE_RESET  = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] TARGET_RESET = 16'h0000;

  // Controller configuration fields
  localparam int CFG_MASTER_EN   = 0;
  localparam int CFG_SPEED_LO    = 1;
  localparam int CFG_RESTART_EN  = 5;
  localparam logic [1:0] SPEED_HIGH = 2'h3;

  // Target register fields
  localparam int TAR_GENERAL_CALL_OR_START_CHOICE = 10;
  localparam int TAR_START_BYTE  = 11;
  localparam int TAR_LONG_ADDR   = 12;

  // Data command fields
  localparam int CMD_SLV_READ_SEL = 8;
  localparam int CMD_READ         = 9;
  localparam int CMD_WIDTH        = 10;

  // Cause flag positions
  localparam int F_SHORT_ADDR_UNACKED   = 0;
  localparam int F_LONG_FIRST_UNACKED   = 1;
  localparam int F_LONG_SECOND_UNACKED  = 2;
  localparam int F_DATA_BYTE_UNACKED    = 3;
  localparam int F_GCALL_UNACKED        = 4;
  localparam int F_GCALL_READ_MISUSE    = 5;
  localparam int F_HS_CODE_ACKED        = 6;
  localparam int F_START_BYTE_ACKED     = 7;
  localparam int F_HS_NO_RESTART        = 8;
  localparam int F_START_BYTE_NO_RSTRT  = 9;
  localparam int F_LONG_READ_NO_RSTRT   = 10;
  localparam int F_MASTER_DISABLED      = 11;
  localparam int F_ARBITRATION_LOST     = 12;
  localparam int F_SLAVE_STALE_FLUSH    = 13;
  localparam int F_SLAVE_BUS_LOST       = 14;
  localparam int F_SLAVE_READ_CONFLICT  = 15;

  // Byte phase of a master acknowledge slot
  typedef enum logic [2:0] {
    PH_SHORT_ADDR  = 3'b000,
    PH_LONG_FIRST  = 3'b001,
    PH_LONG_SECOND = 3'b010,
    PH_DATA        = 3'b011,
    PH_GCALL       = 3'b100,
    PH_START_BYTE  = 3'b101,
    PH_HS_CODE     = 3'b110
  } ack_phase_t;

  // Acknowledge slot report from the master engine
  typedef struct packed {
    logic       valid;
    logic       nack;
    ack_phase_t phase;
  } ack_event_t;

endpackage : abort_cause_pkg

// *** pin_sync.sv ***
/*
  Two-flop synchroniser for bus pins with rising-edge detection on the
  synchronised level.
  Assumes pins are asynchronous to clk_sys_i and change far slower than it.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Pins and synchronised view
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;

  // Edge found on the second flop only, never on the first
  always_comb begin
    meta_nxt  = pin_i;
    level_nxt = meta_r;
    prev_nxt  = level_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      meta_r  <= '1;
      level_r <= '1;
      prev_r  <= '1;
    end else begin
      meta_r  <= meta_nxt;
      level_r <= level_nxt;
      prev_r  <= prev_nxt;
    end
  end

  assign level_o = level_r;
  assign rise_o  = level_r & ~prev_r;

endmodule : pin_sync

// *** abort_cause.sv ***
/*
  Transmit-abort cause detection and recording for a combined master and
  slave two-wire bus controller, with its configuration, target, command
  and cause registers on a simple strobe register port.
  Assumes the master and slave engines run on clk_sys_i and report their
  events as one-cycle pulses; the bus pins arrive asynchronously.
*/
// Local design decision: the strobed register port.
`timescale 1ns/1ns

// Behaviour
// - Slave-read data request answered by command with bit 8 sets flag 15.
// - Slave transmitter losing the bus sets flags 14 and 12 together.
// - While transmitting, data line differing at clock rise means bus lost.
// - Slave read request with stale transmit entries sets flag 13, flushes.
// - Master arbitration loss sets flag 12; with 14 it means slave loss.
// - Master and slave may be active together; causes stay attributable.
// - Master start attempted with master disabled sets flag 11.
// - Restart disabled and long-address master read sets flag 10.
// - Restart disabled and START byte requested sets flag 9.
// - Clearing flag 9 with cause still present drops it one cycle only.
// - Restart disabled and high-speed master transfer sets flag 8.
// - Acknowledged START byte sets flag 7.
// - Acknowledged high-speed master code sets flag 6.
// - Read command following a sent general call sets flag 5.
// - Unacknowledged general call sets flag 4.
// - Master data byte unacknowledged after acknowledged address sets flag 3.
// - Unacknowledged second long-address byte sets flag 2.
// - Unacknowledged first long-address byte sets flag 1.
// - Unacknowledged short address sets flag 0.
module abort_cause
  import abort_cause_pkg::*;
#(
  parameter int FIFO_LEVEL_W = 6
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    sys_rst_i,
  // Register port
  input  wire logic [31:0]             reg_addr_i,
  input  wire logic [15:0]             reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  output logic      [15:0]             reg_rdata_o,
  // Bus pins, observed only
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  // Master engine reports
  input  wire logic                    mst_active_i,
  input  wire logic                    mst_tx_active_i,
  input  wire logic                    mst_start_i,
  input  wire logic                    mst_start_rd_i,
  input  wire ack_event_t              mst_ack_i,
  // Slave engine reports
  input  wire logic                    slv_tx_active_i,
  input  wire logic                    slv_read_req_i,
  input  wire logic                    slv_data_req_i,
  input  wire logic [FIFO_LEVEL_W-1:0] tx_fifo_level_i,
  // Bit currently driven on the data line
  input  wire logic                    sda_drive_bit_i,
  // Outputs to controller
  output logic                         transmit_abort_event_o,
  output logic                         tx_flush_o,
  output logic                         cmd_push_o,
  output logic      [CMD_WIDTH-1:0]    cmd_word_o
);

  // Address match used by both write and read decode
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] base);
    hit = (addr == base);
  endfunction : hit

  // Synchronised pins: bit 1 clock, bit 0 data
  logic [1:0] pin_level;
  logic [1:0] pin_rise;

  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     ({scl_i, sda_i}),
    .level_o   (pin_level),
    .rise_o    (pin_rise)
  );

  logic scl_rise;
  logic sda_level;

  assign scl_rise  = pin_rise[1];
  assign sda_level = pin_level[0];

  // Register state
  logic [15:0]          config_r;
  logic [15:0]          config_nxt;
  logic [15:0]          target_r;
  logic [15:0]          target_nxt;
  logic [15:0]          cause_r;
  logic [15:0]          cause_nxt;
  logic [15:0]          rdata_r;
  logic [15:0]          rdata_nxt;
  logic                 gcall_sent_r;
  logic                 gcall_sent_nxt;
  logic                 reassert9_r;
  logic                 reassert9_nxt;
  logic                 abort_ev_r;
  logic                 abort_ev_nxt;
  logic                 flush_r;
  logic                 flush_nxt;
  logic                 push_r;
  logic                 push_nxt;
  logic [CMD_WIDTH-1:0] cmd_r;
  logic [CMD_WIDTH-1:0] cmd_nxt;

  // Decoded controls
  logic restart_en;
  logic master_en;
  logic high_speed;
  logic long_addr;
  logic sbyte_cause;
  logic wr_cmd;
  logic clr_all;
  logic [15:0] set_vec;

  assign restart_en  = config_r[CFG_RESTART_EN];
  assign master_en   = config_r[CFG_MASTER_EN];
  assign high_speed  = (config_r[CFG_SPEED_LO +: 2] == SPEED_HIGH);
  assign long_addr   = target_r[TAR_LONG_ADDR];
  // Cause of flag 9 persists until software fixes one of its three inputs
  assign sbyte_cause = ~restart_en & target_r[TAR_START_BYTE]
                     & target_r[TAR_GENERAL_CALL_OR_START_CHOICE];
  assign wr_cmd      = reg_wr_i & hit(reg_addr_i, ADDR_DATA_CMD);
  // Reading the clear register is the single clear action
  assign clr_all     = reg_rd_i & hit(reg_addr_i, ADDR_ABORT_CLEAR);

  // Per-cause set terms; master and slave terms are independent
  always_comb begin
    set_vec = 16'h0000;
    // Slave answers a read request with a slave read selector
    if (wr_cmd && slv_data_req_i && reg_wdata_i[CMD_SLV_READ_SEL]) begin
      set_vec[F_SLAVE_READ_CONFLICT] = 1'b1;
    end
    // Ownership check at each clock rise while driving data
    if (scl_rise && slv_tx_active_i && (sda_level != sda_drive_bit_i)) begin
      set_vec[F_SLAVE_BUS_LOST]   = 1'b1;
      set_vec[F_ARBITRATION_LOST] = 1'b1;
    end
    if (scl_rise && mst_tx_active_i && (sda_level != sda_drive_bit_i)) begin
      set_vec[F_ARBITRATION_LOST] = 1'b1;
    end
    // Stale transmit data at a slave read request
    if (slv_read_req_i && (tx_fifo_level_i != '0)) begin
      set_vec[F_SLAVE_STALE_FLUSH] = 1'b1;
    end
    // Checks made when the master tries to start
    if (mst_start_i) begin
      if (!master_en) begin
        set_vec[F_MASTER_DISABLED] = 1'b1;
      end
      if (!restart_en && long_addr && mst_start_rd_i) begin
        set_vec[F_LONG_READ_NO_RSTRT] = 1'b1;
      end
      if (sbyte_cause) begin
        set_vec[F_START_BYTE_NO_RSTRT] = 1'b1;
      end
      if (!restart_en && high_speed) begin
        set_vec[F_HS_NO_RESTART] = 1'b1;
      end
    end
    // Flag 9 comes back one cycle after a premature clear
    if (reassert9_r && sbyte_cause) begin
      set_vec[F_START_BYTE_NO_RSTRT] = 1'b1;
    end
    // Read command queued after a general call
    if (wr_cmd && gcall_sent_r && reg_wdata_i[CMD_READ]) begin
      set_vec[F_GCALL_READ_MISUSE] = 1'b1;
    end
    // Acknowledge slot outcomes of the master
    if (mst_ack_i.valid) begin
      unique case (mst_ack_i.phase)
        PH_SHORT_ADDR: begin
          set_vec[F_SHORT_ADDR_UNACKED] = mst_ack_i.nack;
        end
        PH_LONG_FIRST: begin
          set_vec[F_LONG_FIRST_UNACKED] = mst_ack_i.nack;
        end
        PH_LONG_SECOND: begin
          set_vec[F_LONG_SECOND_UNACKED] = mst_ack_i.nack;
        end
        PH_DATA: begin
          set_vec[F_DATA_BYTE_UNACKED] = mst_ack_i.nack;
        end
        PH_GCALL: begin
          set_vec[F_GCALL_UNACKED] = mst_ack_i.nack;
        end
        PH_START_BYTE: begin
          set_vec[F_START_BYTE_ACKED] = ~mst_ack_i.nack;
        end
        PH_HS_CODE: begin
          set_vec[F_HS_CODE_ACKED] = ~mst_ack_i.nack;
        end
        // Unused phase code 3'b111 sets nothing
        default: begin
        end
      endcase
    end
  end

  // Register writes
  always_comb begin
    config_nxt = config_r;
    target_nxt = target_r;
    if (reg_wr_i && hit(reg_addr_i, ADDR_CONFIG)) begin
      config_nxt = reg_wdata_i;
    end
    if (reg_wr_i && hit(reg_addr_i, ADDR_TARGET)) begin
      target_nxt = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      config_r <= CONFIG_RESET;
      target_r <= TARGET_RESET;
    end else begin
      config_r <= config_nxt;
      target_r <= target_nxt;
    end
  end

  // Cause flags: a set in the clearing cycle wins over the clear
  always_comb begin
    cause_nxt     = (clr_all ? 16'h0000 : cause_r) | set_vec;
    reassert9_nxt = clr_all & cause_r[F_START_BYTE_NO_RSTRT]
                  & ~set_vec[F_START_BYTE_NO_RSTRT];
    // General call remembered until the master goes idle
    gcall_sent_nxt = gcall_sent_r & mst_active_i;
    if (mst_ack_i.valid && mst_ack_i.phase == PH_GCALL && !mst_ack_i.nack) begin
      gcall_sent_nxt = 1'b1;
    end
    abort_ev_nxt  = |(set_vec & ~cause_r) | |(set_vec & {16{clr_all}});
    flush_nxt     = set_vec[F_SLAVE_STALE_FLUSH];
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cause_r      <= CAUSE_RESET;
      reassert9_r  <= 1'b0;
      gcall_sent_r <= 1'b0;
      abort_ev_r   <= 1'b0;
      flush_r      <= 1'b0;
    end else begin
      cause_r      <= cause_nxt;
      reassert9_r  <= reassert9_nxt;
      gcall_sent_r <= gcall_sent_nxt;
      abort_ev_r   <= abort_ev_nxt;
      flush_r      <= flush_nxt;
    end
  end

  // Command entries pass on unless they themselves caused an abort
  always_comb begin
    push_nxt = wr_cmd & ~set_vec[F_SLAVE_READ_CONFLICT]
             & ~set_vec[F_GCALL_READ_MISUSE];
    cmd_nxt  = wr_cmd ? reg_wdata_i[CMD_WIDTH-1:0] : cmd_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      push_r <= 1'b0;
      cmd_r  <= '0;
    end else begin
      push_r <= push_nxt;
      cmd_r  <= cmd_nxt;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, ADDR_CONFIG)) begin
        rdata_nxt = config_r;
      end else if (hit(reg_addr_i, ADDR_TARGET)) begin
        rdata_nxt = target_r;
      end else if (hit(reg_addr_i, ADDR_ABORT_CAUSE)) begin
        rdata_nxt = cause_r;
      end else begin
        rdata_nxt = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o            = rdata_r;
  assign transmit_abort_event_o = abort_ev_r;
  assign tx_flush_o             = flush_r;
  assign cmd_push_o             = push_r;
  assign cmd_word_o             = cmd_r;

endmodule : abort_cause

// *** abort_cause_asserts.sv ***
/*
  Port checker for the abort cause block: register reads, flush and
  command acceptance.
  Assumes it is bound to every abort_cause instance.
*/
`timescale 1ns/1ns
module abort_cause_asserts
  import abort_cause_pkg::*;
#(
  parameter int FIFO_LEVEL_W = 6
) (
  // Clock and reset
  input wire logic                    clk_sys_i,
  input wire logic                    sys_rst_i,
  // Register port
  input wire logic [31:0]             reg_addr_i,
  input wire logic [15:0]             reg_wdata_i,
  input wire logic                    reg_wr_i,
  input wire logic                    reg_rd_i,
  input wire logic [15:0]             reg_rdata_o,
  // Slave reports
  input wire logic                    slv_read_req_i,
  input wire logic                    slv_data_req_i,
  input wire logic [FIFO_LEVEL_W-1:0] tx_fifo_level_i,
  // Outputs to controller
  input wire logic                    tx_flush_o,
  input wire logic                    cmd_push_o,
  input wire logic [CMD_WIDTH-1:0]    cmd_word_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // Decoded requests, shared by several checks; wd_lo serves a_plain_push alone
  logic       cmd_wr;
  logic       stale;
  logic       clash;
  logic       cause_rd;
  logic       clr_rd;
  logic [9:0] wd_lo;
  assign cmd_wr   = reg_wr_i && reg_addr_i == ADDR_DATA_CMD;
  assign stale    = slv_read_req_i && tx_fifo_level_i != '0;
  assign clash    = cmd_wr && reg_wdata_i[8] && slv_data_req_i;
  assign cause_rd = reg_rd_i && reg_addr_i == ADDR_ABORT_CAUSE;
  assign clr_rd   = reg_rd_i && reg_addr_i == ADDR_ABORT_CLEAR;
  assign wd_lo    = reg_wdata_i[9:0];

  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
  a_clear_zero: assert property (clr_rd |=> reg_rdata_o == 16'h0000)
    else $error("clear read not zero");
  a_stale_flush: assert property (stale |=> tx_flush_o)
    else $error("flush missing");
  a_flush_source: assert property (tx_flush_o |-> $past(stale))
    else $error("flush without cause");
  // Set wins over a clear in the same cycle, so only a later clear spoils it
  a_stale_flag: assert property (stale ##1 !clr_rd ##1 cause_rd |=> reg_rdata_o[13])
    else $error("stale flag not read back");
  a_clash_flag: assert property (clash ##1 !clr_rd ##1 cause_rd |=> reg_rdata_o[15])
    else $error("command clash flag not read back");
  a_clash_no_push: assert property (clash |=> !cmd_push_o)
    else $error("clashing command accepted");
  a_plain_push: assert property (cmd_wr && !reg_wdata_i[8] && !reg_wdata_i[9]
    |=> cmd_push_o && cmd_word_o == $past(wd_lo))
    else $error("plain command not pushed");
  a_push_source: assert property (cmd_push_o |-> $past(cmd_wr))
    else $error("push without write");

  c_stale: cover property (stale);
  c_clash: cover property (clash);
  c_push: cover property (cmd_push_o);
endmodule : abort_cause_asserts

bind abort_cause abort_cause_asserts #(.FIFO_LEVEL_W(FIFO_LEVEL_W)) u_chk (
  .clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .slv_read_req_i, .slv_data_req_i, .tx_fifo_level_i,
  .tx_flush_o, .cmd_push_o, .cmd_word_o
);

// *** bus_partner.sv ***
/*
  Remote party on the two-wire bus: makes the link clock inside frames
  and can pull the data line low against the device.
  Assumes pull-ups, so released lines read high.
*/
`timescale 1ns/1ns
module bus_partner (
  // Control from the bench
  input  wire logic frame_i,
  input  wire logic grab_i,
  input  wire logic drive_bit_i,
  // Bus lines as seen by the device
  output logic      scl_o,
  output logic      sda_o
);
  // Clock stands high between frames; odd poll step keeps phase loose
  initial scl_o = 1'b1;
  always begin
    if (frame_i) begin
      scl_o = 1'b0;
      #200;
      scl_o = 1'b1;
      #200;
    end else begin
      scl_o = 1'b1;
      #13;
    end
  end

  // Wired-AND: a grabbing remote wins over a released high bit
  assign sda_o = drive_bit_i & ~grab_i;
endmodule : bus_partner

// *** abort_cause_bench.sv ***
/*
  Self-checking bench for abort_cause: table of master cases, then
  slave, bus loss, clear and reset tests.
  Assumes bus_partner on the pins and a 20 MHz clock.
*/
`timescale 1ns/1ns
module abort_cause_bench;
  import abort_cause_pkg::*;
  // One table row: setup, start or ack event, expected causes
  typedef struct packed {
    logic [15:0] cfg;
    logic [15:0] tgt;
    logic        st;
    logic        rd;
    logic [4:0]  ev;
    logic [15:0] exp;
  } row_t;
  row_t           rows [14] = '{
    '{16'h0000, 16'h0000, 1'b1, 1'b0, 5'h00, 16'h0800},
    '{16'h0001, 16'h0c00, 1'b1, 1'b0, 5'h00, 16'h0200},
    '{16'h0001, 16'h1000, 1'b1, 1'b1, 5'h00, 16'h0400},
    '{16'h0007, 16'h0000, 1'b1, 1'b0, 5'h00, 16'h0100},
    '{16'h0027, 16'h1c00, 1'b1, 1'b1, 5'h00, 16'h0000},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h18, 16'h0001},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h19, 16'h0002},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h1a, 16'h0004},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h1b, 16'h0008},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h1c, 16'h0010},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h16, 16'h0040},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h15, 16'h0080},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h10, 16'h0000},
    '{16'h0021, 16'h0000, 1'b0, 1'b0, 5'h1f, 16'h0000}};
  logic           clk_sys_i = 1'b0;
  logic           sys_rst_i = 1'b1;
  logic [31:0]    reg_addr_i = '0;
  logic [15:0]    reg_wdata_i = '0;
  logic           reg_wr_i = 1'b0;
  logic           reg_rd_i = 1'b0;
  logic           mst_active_i = 1'b1;
  logic           mst_tx_active_i = 1'b0;
  logic           mst_start_i = 1'b0;
  logic           mst_start_rd_i = 1'b0;
  ack_event_t     mst_ack_i = '0;
  logic           slv_tx_active_i = 1'b0;
  logic           slv_read_req_i = 1'b0;
  logic           slv_data_req_i = 1'b0;
  logic [5:0]     tx_fifo_level_i = '0;
  logic           sda_drive_bit_i = 1'b1;
  logic           frame = 1'b0;
  logic           grab = 1'b0;
  logic           scl_i;
  logic           sda_i;
  logic [15:0]    reg_rdata_o;
  logic           transmit_abort_event_o;
  logic           tx_flush_o;
  logic           cmd_push_o;
  logic [9:0]     cmd_word_o;
  logic [15:0]    d;
  int             errors = 0;
  int             samples_checked = 0;
  int             cycles = 0;

  abort_cause u_dut (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .scl_i, .sda_i, .mst_active_i, .mst_tx_active_i,
    .mst_start_i, .mst_start_rd_i, .mst_ack_i, .slv_tx_active_i, .slv_read_req_i,
    .slv_data_req_i, .tx_fifo_level_i, .sda_drive_bit_i, .transmit_abort_event_o,
    .tx_flush_o, .cmd_push_o, .cmd_word_o);
  bus_partner u_far (.frame_i(frame), .grab_i(grab), .drive_bit_i(sda_drive_bit_i),
    .scl_o(scl_i), .sda_o(sda_i));

  // 20 MHz clock
  always #25 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bus cycles leave a gap cycle so no strobe is assigned twice at one edge
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [15:0] v);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Hang guard, well above the expected run length
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    // Reset values, read-only cause register, unmapped place
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h0000);
    wr(ADDR_ABORT_CAUSE, 16'hffff);
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h0000);
    rd(ADDR_CONFIG, d);
    chk(d, CONFIG_RESET);
    rd(32'h5000_13fc, d);
    chk(d, 16'h0000);
    // Table of master start and acknowledge cases
    foreach (rows[i]) begin
      wr(ADDR_CONFIG, rows[i].cfg);
      wr(ADDR_TARGET, rows[i].tgt);
      rd(ADDR_ABORT_CLEAR, d);
      if (rows[i].st) begin
        mst_start_rd_i <= rows[i].rd;
        mst_start_i <= 1'b1;
      end else begin
        mst_ack_i <= 5'h10;
        @(posedge clk_sys_i);
        mst_ack_i <= rows[i].ev;
      end
      @(posedge clk_sys_i);
      mst_start_i <= 1'b0;
      mst_ack_i <= '0;
      rd(ADDR_ABORT_CAUSE, d);
      chk(d, rows[i].exp);
    end
    // Stale flush beside a master address loss in the same cycle
    rd(ADDR_ABORT_CLEAR, d);
    tx_fifo_level_i <= 6'h03;
    slv_read_req_i <= 1'b1;
    mst_ack_i <= 5'h18;
    @(posedge clk_sys_i);
    slv_read_req_i <= 1'b0;
    mst_ack_i <= '0;
    #1 chk({15'h0, tx_flush_o}, 16'h0001);
    chk({15'h0, transmit_abort_event_o}, 16'h0001);
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h2001);
    // Mid-run reset drops every flag
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h0000);
    // Slave data request answered with a slave-read command
    slv_data_req_i <= 1'b1;
    wr(ADDR_DATA_CMD, 16'h0100);
    chk({15'h0, cmd_push_o}, 16'h0000);
    slv_data_req_i <= 1'b0;
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h8000);
    wr(ADDR_DATA_CMD, 16'h00a5);
    chk({5'h0, cmd_push_o, cmd_word_o}, 16'h04a5);
    // Read command after an acknowledged general call
    rd(ADDR_ABORT_CLEAR, d);
    mst_ack_i <= 5'h14;
    @(posedge clk_sys_i);
    mst_ack_i <= '0;
    wr(ADDR_DATA_CMD, 16'h0200);
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h0020);
    mst_active_i <= 1'b0;
    // Bus taken from the slave, then from the master
    for (int k = 0; k < 2; k++) begin
      rd(ADDR_ABORT_CLEAR, d);
      slv_tx_active_i <= (k == 0);
      mst_tx_active_i <= (k == 1);
      grab <= 1'b1;
      frame <= 1'b1;
      repeat (40) @(posedge clk_sys_i);
      frame <= 1'b0;
      grab <= 1'b0;
      slv_tx_active_i <= 1'b0;
      mst_tx_active_i <= 1'b0;
      rd(ADDR_ABORT_CAUSE, d);
      chk(d, k == 0 ? 16'h5000 : 16'h1000);
    end
    // Flag 9 comes back after a clear while its cause stays
    wr(ADDR_CONFIG, 16'h0001);
    wr(ADDR_TARGET, 16'h0c00);
    @(posedge clk_sys_i);
    mst_start_i <= 1'b1;
    @(posedge clk_sys_i);
    mst_start_i <= 1'b0;
    reg_addr_i <= ADDR_ABORT_CLEAR;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_addr_i <= ADDR_ABORT_CAUSE;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, 16'h0000);
    chk({15'h0, transmit_abort_event_o}, 16'h0001);
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h0200);
    wr(ADDR_CONFIG, 16'h0021);
    rd(ADDR_ABORT_CLEAR, d);
    rd(ADDR_ABORT_CAUSE, d);
    chk(d, 16'h0000);
    test_done();
  end
endmodule : abort_cause_bench
